//--- hw/rstopt_ctrl.sv
// Reset sequencer with cause flags, code options and register port
// Functional notes
// - Reset from power, watchdog, brown-out, optional pin
// - Any reset clears arithmetic flags, halts, clears PC
// - After release execution starts at address zero
// - Cause flags at bits seven and six
// - Status register at 086H, arithmetic flags clear
// - Power-up: stable supply, pin, init, warm-up
// - Enabled pin must be high to leave reset
// - Watchdog overflow resets, then init and warm-up
// - Always-on runs in sleep; disable turns off
// - Plain enable stops watchdog in low-power modes
// - Pin falling edge or low resets, external cause unless last cause was power-on
// - General I/O option disables pin reset
// - Normal mode cycle is 4, 8 or 16 clocks
// - Slow mode rate fixed at low clock/4
// - Security option blocks ROM readout
// - Supply below detector level holds reset
// - Detector trigger forces full system reset
`timescale 1ns/1ps
module rstopt_ctrl #(
	parameter int WARMUP = rstopt_pkg::WARMUP_CYCLES
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic supply_ok,
	input wire logic reset_pin_in,
	input wire logic wdt_overflow,
	input wire logic slow_mode,
	input wire logic low_power_mode,
	input wire logic lfclk_tick,
	input wire logic rom_dump_req,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	output logic sys_reset,
	output logic [11:0] pc_start,
	output logic cpu_cycle,
	output logic wdt_run,
	output logic rom_dump_ok,
	output logic shared_io_select,
	output logic irq
);
	// Two-stage synchronisers for asynchronous inputs
	logic [1:0] sup_s_q;
	logic [1:0] pin_s_q;
	logic pin_prev_q;
	rstopt_pkg::rstopt_state_t st_q, st_d;
	logic [15:0] cnt_q, cnt_d;
	logic [1:0] pend_q, pend_d;
	logic [7:0] psf_q, psf_d;
	logic [3:0] ists_q, ists_d;
	logic [3:0] imask_q, imask_d;
	logic [7:0] opt_q, opt_d;
	logic [7:0] rdata_d;
	logic [3:0] div_q, div_d;
	logic cyc_d;
	logic sys_reset_d;
	logic wdt_run_d;
	logic dump_d;
	logic irq_d;
	logic [3:0] ev;
	logic sup;
	logic pin;
	logic pin_en;
	logic pin_fall;
	logic [1:0] fcpu_sel;
	logic [1:0] wdt_sel;
	logic secure;
	logic [3:0] div_lim;

	assign sup = sup_s_q[1];
	assign pin = pin_s_q[1];
	assign fcpu_sel = opt_q[1:0];
	assign wdt_sel = opt_q[3:2];
	assign pin_en = opt_q[4];
	assign secure = opt_q[5];
	assign pin_fall = pin_en && pin_prev_q && !pin;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sup_s_q <= 2'h0;
			pin_s_q <= 2'h0;
			pin_prev_q <= 1'b0;
		end
		else
		begin
			sup_s_q <= {sup_s_q[0], supply_ok};
			pin_s_q <= {pin_s_q[0], reset_pin_in};
			pin_prev_q <= pin_s_q[1];
		end
	end

	// Reset sequencer
	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		pend_d = pend_q;
		ev = 4'h0;
		if (!sup)
		begin
			st_d = rstopt_pkg::ST_POWER;
			pend_d = rstopt_pkg::CAUSE_POR;
			if (st_q == rstopt_pkg::ST_RUN)
				ev[rstopt_pkg::EVT_PWR] = 1'b1;
		end
		else if (pin_en && (!pin || pin_fall) && st_q != rstopt_pkg::ST_POWER)
		begin
			st_d = rstopt_pkg::ST_PIN;
			if (pend_q != rstopt_pkg::CAUSE_POR)
				pend_d = rstopt_pkg::CAUSE_EXT;
			if (st_q == rstopt_pkg::ST_RUN)
				ev[rstopt_pkg::EVT_EXT] = 1'b1;
		end
		else if (wdt_overflow && wdt_sel != rstopt_pkg::WDT_DISABLE
			&& st_q == rstopt_pkg::ST_RUN)
		begin
			st_d = rstopt_pkg::ST_INIT;
			cnt_d = 16'h0000;
			pend_d = rstopt_pkg::CAUSE_WDT;
			ev[rstopt_pkg::EVT_WDT] = 1'b1;
		end
		else
		begin
			case (st_q)
				rstopt_pkg::ST_POWER:
				begin
					st_d = rstopt_pkg::ST_PIN;
				end
				rstopt_pkg::ST_PIN:
				begin
					if (!pin_en || pin)
					begin
						st_d = rstopt_pkg::ST_INIT;
						cnt_d = 16'h0000;
					end
				end
				rstopt_pkg::ST_INIT:
				begin
					cnt_d = cnt_q + 16'h0001;
					if (cnt_q == 16'(rstopt_pkg::INIT_CYCLES - 1))
					begin
						st_d = rstopt_pkg::ST_WARM;
						cnt_d = 16'h0000;
					end
				end
				rstopt_pkg::ST_WARM:
				begin
					cnt_d = cnt_q + 16'h0001;
					if (cnt_q == 16'(WARMUP - 1))
					begin
						st_d = rstopt_pkg::ST_RUN;
						ev[rstopt_pkg::EVT_RUN] = 1'b1;
					end
				end
				rstopt_pkg::ST_RUN:
				begin
					st_d = rstopt_pkg::ST_RUN;
				end
				default:
				begin
					st_d = rstopt_pkg::ST_POWER;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= rstopt_pkg::ST_POWER;
			cnt_q <= 16'h0000;
			pend_q <= rstopt_pkg::CAUSE_POR;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			pend_q <= pend_d;
		end
	end

	// Registers, flags and outputs
	always_comb
	begin
		psf_d = psf_q;
		ists_d = ists_q;
		imask_d = imask_q;
		opt_d = opt_q;
		rdata_d = 8'h00;
		if (st_d != rstopt_pkg::ST_RUN)
		begin
			psf_d[rstopt_pkg::CARRY_BIT] = 1'b0;
			psf_d[rstopt_pkg::DEC_CARRY_BIT] = 1'b0;
			psf_d[rstopt_pkg::ZERO_BIT] = 1'b0;
		end
		if (ev[rstopt_pkg::EVT_RUN])
			psf_d[rstopt_pkg::CAUSE_HI_BIT:rstopt_pkg::CAUSE_LO_BIT] = pend_q;
		if (wr && st_q == rstopt_pkg::ST_RUN && addr == rstopt_pkg::PSF_ADDR)
		begin
			psf_d[7:6] = wdata[7:6];
			psf_d[2:0] = wdata[2:0];
		end
		if (wr && addr == rstopt_pkg::INT_MASK_ADDR)
			imask_d = wdata[3:0];
		if (wr && addr == rstopt_pkg::OPTION_ADDR)
			opt_d = {2'h0, wdata[5:0]};
		if (wr && addr == rstopt_pkg::INT_STATUS_ADDR)
			ists_d = ists_q & ~wdata[3:0];
		ists_d = ists_d | ev;
		if (rd)
		begin
			case (addr)
				rstopt_pkg::PSF_ADDR: rdata_d = {psf_q[7:6], 3'h0, psf_q[2:0]};
				rstopt_pkg::INT_STATUS_ADDR: rdata_d = {4'h0, ists_q};
				rstopt_pkg::INT_MASK_ADDR: rdata_d = {4'h0, imask_q};
				rstopt_pkg::OPTION_ADDR: rdata_d = opt_q;
				rstopt_pkg::STATE_ADDR: rdata_d = {5'h00, st_q};
				default: rdata_d = 8'h00;
			endcase
		end
		sys_reset_d = st_d != rstopt_pkg::ST_RUN;
		irq_d = |(ists_d & imask_d);
		dump_d = rom_dump_req && !secure;
		// Watchdog run qualification
		case (wdt_sel)
			rstopt_pkg::WDT_ALWAYS: wdt_run_d = 1'b1;
			rstopt_pkg::WDT_ENABLE: wdt_run_d = !low_power_mode;
			default: wdt_run_d = 1'b0;
		endcase
		// Instruction cycle divider
		case (fcpu_sel)
			rstopt_pkg::FCPU_DIV4: div_lim = 4'h3;
			rstopt_pkg::FCPU_DIV8: div_lim = 4'h7;
			default: div_lim = 4'hf;
		endcase
		div_d = div_q;
		cyc_d = 1'b0;
		if (sys_reset_d)
			div_d = 4'h0;
		else if (slow_mode)
		begin
			if (lfclk_tick)
			begin
				div_d = (div_q >= 4'h3) ? 4'h0 : div_q + 4'h1;
				cyc_d = div_q >= 4'h3;
			end
		end
		else
		begin
			div_d = (div_q >= div_lim) ? 4'h0 : div_q + 4'h1;
			cyc_d = div_q >= div_lim;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			psf_q <= rstopt_pkg::PSF_RESET;
			ists_q <= 4'h0;
			imask_q <= 4'h0;
			opt_q <= rstopt_pkg::OPTION_RESET;
			rdata <= 8'h00;
			div_q <= 4'h0;
			cpu_cycle <= 1'b0;
			sys_reset <= 1'b1;
			wdt_run <= 1'b0;
			rom_dump_ok <= 1'b0;
			shared_io_select <= 1'b0;
			irq <= 1'b0;
			pc_start <= rstopt_pkg::PC_RESET;
		end
		else
		begin
			psf_q <= psf_d;
			ists_q <= ists_d;
			imask_q <= imask_d;
			opt_q <= opt_d;
			rdata <= rdata_d;
			div_q <= div_d;
			cpu_cycle <= cyc_d;
			sys_reset <= sys_reset_d;
			wdt_run <= wdt_run_d;
			rom_dump_ok <= dump_d;
			shared_io_select <= !opt_d[4];
			irq <= irq_d;
			pc_start <= rstopt_pkg::PC_RESET;
		end
	end
endmodule : rstopt_ctrl

//--- hw/rstopt_pkg.sv
// Package of constants for the reset and option controller
package rstopt_pkg;
	localparam logic [7:0] PSF_ADDR = 8'h86;
	localparam logic [7:0] INT_STATUS_ADDR = 8'h90;
	localparam logic [7:0] INT_MASK_ADDR = 8'h91;
	localparam logic [7:0] OPTION_ADDR = 8'h92;
	localparam logic [7:0] STATE_ADDR = 8'h93;
	localparam int CAUSE_HI_BIT = 7;
	localparam int CAUSE_LO_BIT = 6;
	localparam int CARRY_BIT = 2;
	localparam int DEC_CARRY_BIT = 1;
	localparam int ZERO_BIT = 0;
	localparam logic [1:0] CAUSE_WDT = 2'h0;
	localparam logic [1:0] CAUSE_POR = 2'h2;
	localparam logic [1:0] CAUSE_EXT = 2'h3;
	localparam logic [7:0] PSF_RESET = 8'h00;
	localparam logic [7:0] OPTION_RESET = 8'h10;
	localparam logic [1:0] FCPU_DIV4 = 2'h0;
	localparam logic [1:0] FCPU_DIV8 = 2'h1;
	localparam logic [1:0] FCPU_DIV16 = 2'h2;
	localparam logic [1:0] WDT_ALWAYS = 2'h0;
	localparam logic [1:0] WDT_ENABLE = 2'h1;
	localparam logic [1:0] WDT_DISABLE = 2'h2;
	localparam logic [11:0] PC_RESET = 12'h000;
	localparam int WARMUP_NS = 1000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int WARMUP_CYCLES = (WARMUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_CYCLES = 4;
	localparam int EVT_PWR = 0;
	localparam int EVT_WDT = 1;
	localparam int EVT_EXT = 2;
	localparam int EVT_RUN = 3;
	typedef enum logic [2:0]
	{
		ST_POWER = 3'b000,
		ST_PIN = 3'b001,
		ST_INIT = 3'b010,
		ST_WARM = 3'b011,
		ST_RUN = 3'b100
	} rstopt_state_t;
endpackage : rstopt_pkg

//--- tb/reset_and_option_control_tb.sv
// Testbench for the reset and option controller
`timescale 1ns/1ps
module reset_and_option_control_tb;
	logic clk = 0, rst_n = 0, pwr_on = 0, pin_push = 0, wdt_overflow = 0, slow_mode = 0;
	logic low_power_mode = 0, lfclk_tick = 0, rom_dump_req = 0, wr = 0, rd = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic [2:0] lf_cnt = 3'h0;
	logic supply_ok, reset_pin_in, sys_reset, cpu_cycle, wdt_run, rom_dump_ok, sio, irq;
	logic [11:0] pc_start;
	int n_mismatch = 0, checked = 0, n, k;
	rstopt_ext_model i_ext (.clk(clk), .pwr_on(pwr_on), .pin_push(pin_push),
		.supply_ok(supply_ok), .reset_pin_in(reset_pin_in));
	rstopt_ctrl #(.WARMUP(4)) i_dut (.clk(clk), .rst_n(rst_n), .supply_ok(supply_ok),
		.reset_pin_in(reset_pin_in), .wdt_overflow(wdt_overflow), .slow_mode(slow_mode),
		.low_power_mode(low_power_mode), .lfclk_tick(lfclk_tick), .rom_dump_req(rom_dump_req),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sys_reset(sys_reset),
		.pc_start(pc_start), .cpu_cycle(cpu_cycle), .wdt_run(wdt_run),
		.rom_dump_ok(rom_dump_ok), .shared_io_select(sio), .irq(irq));
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		lf_cnt <= lf_cnt + 3'h1;
		lfclk_tick <= (lf_cnt == 3'h7);
	end
	task end_sim;
		if (n_mismatch == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	task chk(input logic [11:0] g, input logic [11:0] e);
		checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task step(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : step
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		step(1);
		wr <= 1;
		addr <= a;
		wdata <= d;
		step(1);
		wr <= 0;
	endtask : wr_reg
	task rd_chk(input logic [7:0] a, input logic [7:0] e);
		step(1);
		rd <= 1;
		addr <= a;
		step(1);
		rd <= 0;
		chk(rdata, e);
	endtask : rd_chk
	task wait_for(input logic want_reset);
		int i;
		for (i = 0; i < 300 && (sys_reset !== want_reset); i++)
			step(1);
		if (sys_reset !== want_reset)
		begin
			n_mismatch++;
			end_sim();
		end
	endtask : wait_for
	task gap(output int c);
		int i;
		for (k = 0; k < 2; k++)
		begin
			for (i = 0; i < 100 && cpu_cycle !== 1'b1; i++)
				step(1);
			step(1);
		end
		for (c = 1; c < 100 && cpu_cycle !== 1'b1; c++)
			step(1);
	endtask : gap
	task wmode(input logic [1:0] m, input logic lp, input logic e);
		low_power_mode <= lp;
		wr_reg(rstopt_pkg::OPTION_ADDR, {4'h1, m, 2'h0});
		step(2);
		chk(wdt_run, e);
	endtask : wmode
	task s_power;
		step(10);
		chk(sys_reset, 1);
		pwr_on <= 1;
		wait_for(0);
		chk(pc_start, 12'h000);
		rd_chk(rstopt_pkg::PSF_ADDR, 8'h80);
		rd_chk(rstopt_pkg::INT_STATUS_ADDR, 8'h08);
		rd_chk(8'h40, 8'h00);
		wr_reg(rstopt_pkg::INT_MASK_ADDR, 8'h0F);
		step(2);
		chk(irq, 1);
		wr_reg(rstopt_pkg::INT_STATUS_ADDR, 8'h0F);
		step(2);
		chk(irq, 0);
		wr_reg(rstopt_pkg::INT_MASK_ADDR, 8'h00);
		step(2);
		chk(irq, 0);
	endtask : s_power
	task s_resets;
		wdt_overflow <= 1;
		step(1);
		wdt_overflow <= 0;
		step(3);
		chk(sys_reset, 1);
		wait_for(0);
		rd_chk(rstopt_pkg::PSF_ADDR, 8'h00);
		wr_reg(rstopt_pkg::PSF_ADDR, 8'h07);
		rd_chk(rstopt_pkg::PSF_ADDR, 8'h07);
		pin_push <= 1;
		step(20);
		chk(sys_reset, 1);
		pin_push <= 0;
		wait_for(0);
		rd_chk(rstopt_pkg::PSF_ADDR, 8'hC0);
	endtask : s_resets
	task s_options;
		wr_reg(rstopt_pkg::OPTION_ADDR, 8'h00);
		pin_push <= 1;
		step(20);
		chk(sys_reset, 0);
		chk(sio, 1);
		pin_push <= 0;
		for (n = 0; n < 3; n++)
		begin
			wr_reg(rstopt_pkg::OPTION_ADDR, n[7:0]);
			gap(k);
			chk(k, 4 << n);
		end
		slow_mode <= 1;
		gap(k);
		chk(k, 32);
		slow_mode <= 0;
		wmode(rstopt_pkg::WDT_ALWAYS, 1, 1);
		wmode(rstopt_pkg::WDT_ENABLE, 1, 0);
		wmode(rstopt_pkg::WDT_DISABLE, 0, 0);
		wmode(rstopt_pkg::WDT_ENABLE, 0, 1);
		rom_dump_req <= 1;
		wr_reg(rstopt_pkg::OPTION_ADDR, 8'h20);
		step(3);
		chk(rom_dump_ok, 0);
		wr_reg(rstopt_pkg::OPTION_ADDR, 8'h00);
		step(3);
		chk(rom_dump_ok, 1);
	endtask : s_options
	initial
	begin
		step(5);
		rst_n <= 1;
		s_power();
		s_resets();
		s_options();
		end_sim();
	end
endmodule : reset_and_option_control_tb

//--- tb/rstopt_ctrl_sva.sv
// Assertion checker for the reset and option controller
`timescale 1ns/1ps
module rstopt_ctrl_sva #(
	parameter int WARMUP = 4
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic supply_ok,
	input wire logic reset_pin_in,
	input wire logic wdt_overflow,
	input wire logic slow_mode,
	input wire logic rom_dump_req,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic sys_reset,
	input wire logic [11:0] pc_start,
	input wire logic cpu_cycle,
	input wire logic rom_dump_ok,
	input wire logic shared_io_select
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_pc_zero: assert property (pc_start == 12'h000)
		else $error("start address not zero");
	chk_halt_reset: assert property (sys_reset |-> !cpu_cycle)
		else $error("cycle during reset");
	chk_supply_hold: assert property (!supply_ok [*4] |=> sys_reset)
		else $error("low supply not held in reset");
	chk_wdt_reset: assert property (wdt_overflow |-> ##[1:3] sys_reset)
		else $error("watchdog overflow without reset");
	chk_pin_reset: assert property ((!reset_pin_in && !shared_io_select) [*5] |=> sys_reset)
		else $error("low pin without reset");
	chk_read_zero: assert property (rdata != 8'h00 |-> $past(rd))
		else $error("read data without read");
	chk_dump_block: assert property (rom_dump_ok |-> $past(rom_dump_req))
		else $error("readout without request");
	chk_cycle_gap: assert property (cpu_cycle && !slow_mode |=> !cpu_cycle [*3])
		else $error("normal cycle too short");
	chk_slow_gap: assert property (cpu_cycle && slow_mode |=> !cpu_cycle [*8])
		else $error("slow cycle too short");
endmodule : rstopt_ctrl_sva
bind rstopt_ctrl rstopt_ctrl_sva #(.WARMUP(WARMUP)) i_sva (.clk(clk), .rst_n(rst_n),
	.supply_ok(supply_ok), .reset_pin_in(reset_pin_in), .wdt_overflow(wdt_overflow),
	.slow_mode(slow_mode), .rom_dump_req(rom_dump_req), .rd(rd), .rdata(rdata),
	.sys_reset(sys_reset), .pc_start(pc_start), .cpu_cycle(cpu_cycle),
	.rom_dump_ok(rom_dump_ok), .shared_io_select(shared_io_select));

//--- tb/rstopt_ext_model.sv
// Model of the external reset circuit and supply monitor
`timescale 1ns/1ps
module rstopt_ext_model
(
	input wire logic clk,
	input wire logic pwr_on,
	input wire logic pin_push,
	output logic supply_ok,
	output logic reset_pin_in
);
	always_ff @(posedge clk)
	begin
		supply_ok <= pwr_on;
		reset_pin_in <= !pin_push;
	end
endmodule : rstopt_ext_model
